/* logic/sosc_pkg.sv */
// Package: shared constants, types and carriers for the safety output start control
package sosc_pkg;

    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned MS_DIV = CLK_HZ / 1000;
    localparam int unsigned T_RESTART_MS = 80;
    localparam int unsigned T_PRESS_MIN_MS = 500;
    localparam int unsigned T_PRESS_MAX_MS = 5000;
    localparam int unsigned T_FB_OPEN_MS = 350;
    localparam int unsigned T_FB_CLOSE_MS = 100;
    localparam int unsigned T_DEBOUNCE_MS = 10;
    localparam int unsigned MAX_SLAVES = 2;
    localparam int unsigned SLOT_MS = 1;

    typedef enum logic [3:0] {
        SOSC_ST_INIT = 4'h1,
        SOSC_ST_ON = 4'h2,
        SOSC_ST_OFF = 4'h4,
        SOSC_ST_LOCK = 4'h8
    } sosc_state_e;

    // Sensing inputs from the optics front end and output readback
    typedef struct packed {
        logic beam_blocked;
        logic extraneous_light;
        logic chan_fault;
        logic wiring_ok;
        logic optic_sync;
    } sosc_sense_s;

    // Status reported alongside the safety outputs
    typedef struct packed {
        logic lockout;
        logic fb_fault;
        logic armed;
    } sosc_status_s;

endpackage

/* logic/sosc_press_timer.sv */
// Start button synchroniser, debouncer and press duration measurement
module sosc_press_timer #(
    parameter int unsigned DEB_MS = sosc_pkg::T_DEBOUNCE_MS,
    parameter int unsigned MIN_MS = sosc_pkg::T_PRESS_MIN_MS,
    parameter int unsigned MAX_MS = sosc_pkg::T_PRESS_MAX_MS
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ms_tick,
    input wire logic button_pin,
    output logic start_valid
);

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic level;
        logic [15:0] deb_cnt;
        logic [15:0] press_ms;
        logic valid;
    } sosc_pt_s;

    sosc_pt_s s_r;
    sosc_pt_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.valid = 1'b0;
        s_nxt.sync1 = button_pin;
        s_nxt.sync2 = s_r.sync1;
        // Debounce: level only follows after a stable run of DEB_MS ticks
        if (s_r.sync2 == s_r.level) begin
            s_nxt.deb_cnt = 16'h0000;
        end else if (ms_tick) begin
            if (s_r.deb_cnt >= 16'(DEB_MS - 1)) begin
                s_nxt.level = s_r.sync2;
                s_nxt.deb_cnt = 16'h0000;
            end else begin
                s_nxt.deb_cnt = s_r.deb_cnt + 16'h0001;
            end
        end
        if (s_r.level && ms_tick && s_r.press_ms != 16'hFFFF) begin
            s_nxt.press_ms = s_r.press_ms + 16'h0001;
        end
        // Release edge judges the press window
        if (s_r.level && !s_nxt.level) begin
            s_nxt.valid = (s_r.press_ms >= 16'(MIN_MS)) && (s_r.press_ms <= 16'(MAX_MS));
            s_nxt.press_ms = 16'h0000;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign start_valid = s_r.valid;

    chk_press_window: assert property (@(posedge mclk) disable iff (rst)
        start_valid |-> $past(s_r.press_ms) >= 16'(MIN_MS) && $past(s_r.press_ms) <= 16'(MAX_MS))
        else $error("start accepted outside press window");
    chk_release_edge: assert property (@(posedge mclk) disable iff (rst)
        start_valid |-> $past(s_r.level) && !s_r.level)
        else $error("start not on button release");

endmodule

/* logic/sosc_core.sv */
// Safety output start control: output switching, restart, feedback check, cascade
// What this block does
// - Blocked beam forces both safety outputs OFF.
// - Fault on either output channel forces both outputs OFF.
// - Extraneous light at the receiver forces both outputs OFF.
// - Except at automatic-mode power-up, a fault latches outputs OFF until valid restart.
// - Automatic mode: outputs ON at power-up if wired, fault-free, field clear.
// - Monitored mode: ON again only if conditions hold and 80 ms OFF elapsed.
// - Button held at least 0.5 s; start fires on release edge.
// - Restart accepted only for press between 0.5 s and 5 s.
// - Feedback must open within 350 ms after outputs ON, else fault.
// - Feedback must close within 100 ms after outputs OFF, else fault.
// - Contactor feedback fault enters safe state with outputs OFF.
// - Feedback checked on every output change and before restart.
// - A master supports at most two cascaded slaves.
// - Master merges slave results and gives slaves separate time slots.
// - Any unit works as master or slave.
// - Transmitter and receiver synchronise optically only.
module sosc_core #(
    parameter int unsigned NUM_SLAVES = sosc_pkg::MAX_SLAVES,
    parameter int unsigned MS_CYCLES = sosc_pkg::MS_DIV
) (
    input wire logic mclk,
    input wire logic rst,
    input wire sosc_pkg::sosc_sense_s sense_pin,
    input wire logic auto_start_pin,
    input wire logic fb_enable_pin,
    input wire logic fb_closed_pin,
    input wire logic start_button_pin,
    input wire logic master_role_pin,
    input wire logic [sosc_pkg::MAX_SLAVES-1:0] slave_clear_pin,
    input wire logic [sosc_pkg::MAX_SLAVES-1:0] slave_present_pin,
    output logic safety_switching_output_a,
    output logic safety_switching_output_b,
    output logic [sosc_pkg::MAX_SLAVES-1:0] slave_slot_enable,
    output logic field_clear_out,
    output sosc_pkg::sosc_status_s status
);

    localparam int unsigned SLV = sosc_pkg::MAX_SLAVES;

    typedef struct packed {
        logic [4:0] sense1;
        logic [4:0] sense2;
        logic [3:0] ctl1;
        logic [3:0] ctl2;
        logic [SLV-1:0] slv1;
        logic [SLV-1:0] slv2;
        logic [SLV-1:0] prs1;
        logic [SLV-1:0] prs2;
        logic [15:0] div_cnt;
        logic ms_tick;
        sosc_pkg::sosc_state_e st;
        logic [15:0] off_ms;
        logic [15:0] fb_ms;
        logic fb_pend_open;
        logic fb_pend_close;
        logic fb_fault;
        logic out_on;
        logic [7:0] slot_ms;
        logic [SLV-1:0] slot;
        logic [SLV-1:0] field_clear_slv;
    } sosc_core_s;

    sosc_core_s s_r;
    sosc_core_s s_nxt;
    logic start_valid;
    sosc_pkg::sosc_sense_s sn;
    logic auto_mode;
    logic fb_en;
    logic fb_closed;
    logic is_master;
    logic [SLV-1:0] slv_clear;
    logic [SLV-1:0] slv_present;
    logic local_clear;
    logic cascade_clear;
    logic run_ok;
    logic restart_ok;

    sosc_press_timer u_press (
        .mclk(mclk),
        .rst(rst),
        .ms_tick(s_r.ms_tick),
        .button_pin(start_button_pin),
        .start_valid(start_valid)
    );

    // Synchronised views of the pins; only the second stage is read
    assign sn = sosc_pkg::sosc_sense_s'(s_r.sense2);
    assign auto_mode = s_r.ctl2[0];
    assign fb_en = s_r.ctl2[1];
    assign fb_closed = s_r.ctl2[2];
    assign is_master = s_r.ctl2[3];
    assign slv_clear = s_r.slv2;
    assign slv_present = s_r.prs2;

    // Optical sync lost means no trustworthy field reading
    assign local_clear = !sn.beam_blocked && sn.optic_sync;
    // Master merges slave verdicts; absent slaves count as clear
    assign cascade_clear = !is_master || (&(s_r.field_clear_slv | ~slv_present));
    assign run_ok = local_clear && cascade_clear && !sn.extraneous_light
        && !sn.chan_fault && sn.wiring_ok;
    // Feedback must read closed before a restart may be granted
    assign restart_ok = run_ok && !s_r.fb_fault && (!fb_en || fb_closed);

    always_comb begin
        s_nxt = s_r;
        s_nxt.sense1 = sense_pin;
        s_nxt.sense2 = s_r.sense1;
        s_nxt.ctl1 = {master_role_pin, fb_closed_pin, fb_enable_pin, auto_start_pin};
        s_nxt.ctl2 = s_r.ctl1;
        s_nxt.slv1 = slave_clear_pin;
        s_nxt.slv2 = s_r.slv1;
        s_nxt.prs1 = slave_present_pin;
        s_nxt.prs2 = s_r.prs1;

        s_nxt.ms_tick = 1'b0;
        if (s_r.div_cnt >= 16'(MS_CYCLES - 1)) begin
            s_nxt.div_cnt = 16'h0000;
            s_nxt.ms_tick = 1'b1;
        end else begin
            s_nxt.div_cnt = s_r.div_cnt + 16'h0001;
        end

        // Slots rotate one slave per period so slave emitters never overlap
        if (s_r.ms_tick) begin
            if (s_r.slot_ms >= 8'(sosc_pkg::SLOT_MS - 1)) begin
                s_nxt.slot_ms = 8'h00;
                s_nxt.slot = {s_r.slot[SLV-2:0], s_r.slot[SLV-1]};
                if (s_r.slot == '0) begin
                    s_nxt.slot = SLV'(1);
                end
            end else begin
                s_nxt.slot_ms = s_r.slot_ms + 8'h01;
            end
        end
        for (int i = 0; i < SLV; i++) begin
            // A slave verdict only refreshes inside its own slot
            if (s_r.slot[i] && i < NUM_SLAVES) begin
                s_nxt.field_clear_slv[i] = slv_clear[i];
            end
            if (!slv_present[i]) begin
                s_nxt.field_clear_slv[i] = 1'b0;
            end
        end

        if (s_r.ms_tick && s_r.off_ms != 16'hFFFF) begin
            s_nxt.off_ms = s_r.off_ms + 16'h0001;
        end
        if (s_r.ms_tick && s_r.fb_ms != 16'hFFFF) begin
            s_nxt.fb_ms = s_r.fb_ms + 16'h0001;
        end

        // Feedback deadlines after each output change
        if (fb_en && s_r.fb_pend_open) begin
            if (!fb_closed) begin
                s_nxt.fb_pend_open = 1'b0;
            end else if (s_r.fb_ms >= 16'(sosc_pkg::T_FB_OPEN_MS)) begin
                s_nxt.fb_fault = 1'b1;
            end
        end
        if (fb_en && s_r.fb_pend_close) begin
            if (fb_closed) begin
                s_nxt.fb_pend_close = 1'b0;
            end else if (s_r.fb_ms >= 16'(sosc_pkg::T_FB_CLOSE_MS)) begin
                s_nxt.fb_fault = 1'b1;
            end
        end
        if (!fb_en) begin
            s_nxt.fb_pend_open = 1'b0;
            s_nxt.fb_pend_close = 1'b0;
        end

        case (s_r.st)
            sosc_pkg::SOSC_ST_INIT: begin
                s_nxt.out_on = 1'b0;
                // Synchronisers read zero until filled, so monitored mode waits for a tick
                if (auto_mode && restart_ok) begin
                    s_nxt.st = sosc_pkg::SOSC_ST_ON;
                    s_nxt.out_on = 1'b1;
                    s_nxt.fb_pend_open = fb_en;
                    s_nxt.fb_ms = 16'h0000;
                end else if (!auto_mode && s_r.ms_tick) begin
                    s_nxt.st = sosc_pkg::SOSC_ST_OFF;
                    s_nxt.off_ms = 16'h0000;
                end
            end
            sosc_pkg::SOSC_ST_ON: begin
                if (sn.chan_fault || s_nxt.fb_fault) begin
                    s_nxt.st = sosc_pkg::SOSC_ST_LOCK;
                    s_nxt.out_on = 1'b0;
                    s_nxt.fb_pend_open = 1'b0;
                    s_nxt.fb_pend_close = fb_en;
                    s_nxt.fb_ms = 16'h0000;
                    s_nxt.off_ms = 16'h0000;
                end else if (!run_ok) begin
                    s_nxt.st = sosc_pkg::SOSC_ST_OFF;
                    s_nxt.out_on = 1'b0;
                    s_nxt.fb_pend_open = 1'b0;
                    s_nxt.fb_pend_close = fb_en;
                    s_nxt.fb_ms = 16'h0000;
                    s_nxt.off_ms = 16'h0000;
                end
            end
            sosc_pkg::SOSC_ST_OFF: begin
                if (sn.chan_fault || s_nxt.fb_fault) begin
                    s_nxt.st = sosc_pkg::SOSC_ST_LOCK;
                end else if (restart_ok && !s_r.fb_pend_close && (auto_mode
                        || (start_valid && s_r.off_ms >= 16'(sosc_pkg::T_RESTART_MS)))) begin
                    s_nxt.st = sosc_pkg::SOSC_ST_ON;
                    s_nxt.out_on = 1'b1;
                    s_nxt.fb_pend_open = fb_en;
                    s_nxt.fb_ms = 16'h0000;
                end
            end
            sosc_pkg::SOSC_ST_LOCK: begin
                s_nxt.out_on = 1'b0;
                // Only a valid button restart clears a latched fault
                if (start_valid && run_ok && (!fb_en || fb_closed)
                        && s_r.off_ms >= 16'(sosc_pkg::T_RESTART_MS)) begin
                    s_nxt.st = sosc_pkg::SOSC_ST_OFF;
                    s_nxt.fb_fault = 1'b0;
                    s_nxt.fb_pend_close = 1'b0;
                end
            end
            default: begin
                s_nxt.st = sosc_pkg::SOSC_ST_LOCK;
                s_nxt.out_on = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
            s_r.st <= sosc_pkg::SOSC_ST_INIT;
        end else begin
            s_r <= s_nxt;
        end
    end

    // One flop feeds both channels so they cannot diverge
    assign safety_switching_output_a = s_r.out_on;
    assign safety_switching_output_b = s_r.out_on;
    assign slave_slot_enable = is_master ? s_r.slot : '0;
    assign field_clear_out = s_r.out_on;
    assign status = '{
        lockout: (s_r.st == sosc_pkg::SOSC_ST_LOCK),
        fb_fault: s_r.fb_fault,
        armed: (s_r.st == sosc_pkg::SOSC_ST_OFF)
    };

    sequence seq_blocked;
        sn.beam_blocked || sn.extraneous_light || sn.chan_fault;
    endsequence

    chk_off_on_hazard: assert property (@(posedge mclk) disable iff (rst)
        seq_blocked |=> !safety_switching_output_a)
        else $error("output on while hazard present");
    chk_chan_fault_lock: assert property (@(posedge mclk) disable iff (rst)
        (sn.chan_fault && s_r.out_on) |=> status.lockout)
        else $error("channel fault did not lock");
    chk_lock_holds_off: assert property (@(posedge mclk) disable iff (rst)
        status.lockout |-> !safety_switching_output_a)
        else $error("output on during lockout");
    chk_monitored_gap: assert property (@(posedge mclk) disable iff (rst)
        ($rose(s_r.out_on) && $past(s_r.st) == sosc_pkg::SOSC_ST_OFF && !$past(auto_mode))
        |-> $past(s_r.off_ms) >= 16'(sosc_pkg::T_RESTART_MS) && $past(start_valid))
        else $error("monitored restart too early");
    chk_fb_open_late: assert property (@(posedge mclk) disable iff (rst)
        (s_r.fb_pend_open && fb_en && fb_closed
            && s_r.fb_ms >= 16'(sosc_pkg::T_FB_OPEN_MS)) |=> s_r.fb_fault)
        else $error("missed feedback open deadline");
    chk_fb_close_late: assert property (@(posedge mclk) disable iff (rst)
        (s_r.fb_pend_close && fb_en && !fb_closed
            && s_r.fb_ms >= 16'(sosc_pkg::T_FB_CLOSE_MS)) |=> s_r.fb_fault)
        else $error("missed feedback close deadline");
    chk_fb_safe: assert property (@(posedge mclk) disable iff (rst)
        s_r.fb_fault |=> !safety_switching_output_a)
        else $error("output on with feedback fault");
    chk_chan_equal: assert property (@(posedge mclk) disable iff (rst)
        safety_switching_output_a == safety_switching_output_b)
        else $error("channels differ");
    chk_slot_single: assert property (@(posedge mclk) disable iff (rst)
        $onehot0(s_r.slot))
        else $error("two slave slots active");

    sequence seq_lock_exit;
        status.lockout ##1 !status.lockout;
    endsequence

    chk_lock_exit_press: assert property (@(posedge mclk) disable iff (rst)
        seq_lock_exit |-> $past(start_valid))
        else $error("lockout left without restart press");
    chk_fb_not_early: assert property (@(posedge mclk) disable iff (rst)
        $rose(s_r.fb_fault) |-> $past(s_r.fb_ms) >= 16'(sosc_pkg::T_FB_CLOSE_MS))
        else $error("feedback fault before deadline");
    chk_check_on_open: assert property (@(posedge mclk) disable iff (rst)
        ($rose(s_r.out_on) && $past(fb_en)) |-> s_r.fb_pend_open)
        else $error("no feedback check after switch on");
    chk_check_on_close: assert property (@(posedge mclk) disable iff (rst)
        ($fell(s_r.out_on) && $past(fb_en)) |-> s_r.fb_pend_close)
        else $error("no feedback check after switch off");

endmodule

/* dv/sosc_partner.sv */
// Contactor pair with N/C feedback contacts, driven directly by the safety output
module sosc_partner #(
    parameter int unsigned DELAY = 20
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic out_on,
    input wire logic stuck,
    output logic fb_closed
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_r;

    // N/C loop opens when energised; stuck welds the contacts where they are
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fb_closed <= 1'b1;
            cnt_r <= 8'h00;
        end else if (stuck || fb_closed != out_on) begin
            cnt_r <= 8'h00;
        end else if (cnt_r == 8'(DELAY - 1)) begin
            fb_closed <= ~out_on;
            cnt_r <= 8'h00;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
endmodule

/* dv/sosc_core_test.sv */
// Self-checking testbench for the safety output start control core
module sosc_core_test;
    timeunit 1ns;
    timeprecision 1ps;
    // Shortened millisecond so the 5 s press limit fits the run
    localparam int MSC = 4;
    logic mclk, rst, auto_s, fb_en, btn, master, stuck, oa, ob, fclr, fb_closed;
    sosc_pkg::sosc_sense_s sense;
    sosc_pkg::sosc_status_s status;
    logic [1:0] sl_clear, sl_present, slots;
    int err_total, compares;

    sosc_core #(.MS_CYCLES(MSC)) DUT (.mclk(mclk), .rst(rst), .sense_pin(sense),
        .auto_start_pin(auto_s), .fb_enable_pin(fb_en), .fb_closed_pin(fb_closed),
        .start_button_pin(btn), .master_role_pin(master), .slave_clear_pin(sl_clear),
        .slave_present_pin(sl_present), .safety_switching_output_a(oa),
        .safety_switching_output_b(ob), .slave_slot_enable(slots),
        .field_clear_out(fclr), .status(status));
    sosc_partner #(.DELAY(20)) contactor (.mclk(mclk), .rst(rst), .out_on(oa),
        .stuck(stuck), .fb_closed(fb_closed));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic chk(input string nm, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic outs(input logic e);
        chk("output a", e, oa);
        chk("output b", e, ob);
    endtask

    task automatic wait_out(input logic e, input int ms);
        int n;
        n = 0;
        while (oa !== e && n < ms * MSC) begin
            cyc(1);
            n++;
        end
        outs(e);
    endtask

    task automatic set_sense(input int i, input logic v);
        @(posedge mclk);
        sense[i] <= v;
    endtask

    // Operator holds the button, then releases and waits past debounce
    task automatic press(input int ms);
        @(posedge mclk);
        btn <= 1'b1;
        cyc(ms * MSC);
        @(posedge mclk);
        btn <= 1'b0;
        cyc(20 * MSC);
    endtask

    task automatic t_hazard();
        for (int i = 3; i <= 4; i++) begin
            set_sense(i, 1'b1);
            cyc(1);
            outs(1'b1);
            cyc(2);
            outs(1'b0);
            set_sense(i, 1'b0);
            wait_out(1'b1, 200);
        end
    endtask

    task automatic t_fault();
        @(posedge mclk);
        auto_s <= 1'b0;
        set_sense(2, 1'b1);
        cyc(3);
        outs(1'b0);
        chk("lockout set", 1'b1, status.lockout);
        set_sense(2, 1'b0);
        cyc(100 * MSC);
        outs(1'b0);
        press(300);
        chk("lockout short press", 1'b1, status.lockout);
        press(5200);
        chk("lockout long press", 1'b1, status.lockout);
        press(600);
        chk("lockout cleared", 1'b0, status.lockout);
        chk("armed", 1'b1, status.armed);
        press(510);
        wait_out(1'b1, 1);
        // Release lands only ~60 ms after the outputs dropped
        @(posedge mclk);
        btn <= 1'b1;
        cyc(550 * MSC);
        set_sense(4, 1'b1);
        cyc(10 * MSC);
        set_sense(4, 1'b0);
        cyc(40 * MSC);
        @(posedge mclk);
        btn <= 1'b0;
        cyc(20 * MSC);
        outs(1'b0);
        @(posedge mclk);
        btn <= 1'b1;
        cyc(600 * MSC);
        outs(1'b0);
        @(posedge mclk);
        btn <= 1'b0;
        wait_out(1'b1, 20);
        @(posedge mclk);
        auto_s <= 1'b1;
    endtask

    task automatic t_fb();
        set_sense(4, 1'b1);
        cyc(50 * MSC);
        @(posedge mclk);
        stuck <= 1'b1;
        set_sense(4, 1'b0);
        wait_out(1'b1, 50);
        cyc(340 * MSC);
        chk("fb fault early", 1'b0, status.fb_fault);
        cyc(12 * MSC);
        chk("fb open deadline", 1'b1, status.fb_fault);
        outs(1'b0);
        @(posedge mclk);
        stuck <= 1'b0;
        press(600);
        wait_out(1'b1, 1);
        cyc(20 * MSC);
        @(posedge mclk);
        stuck <= 1'b1;
        set_sense(4, 1'b1);
        cyc(95 * MSC);
        chk("fb close early", 1'b0, status.fb_fault);
        cyc(7 * MSC);
        chk("fb close deadline", 1'b1, status.fb_fault);
        set_sense(4, 1'b0);
        press(600);
        chk("restart with open loop", 1'b1, status.lockout);
        @(posedge mclk);
        stuck <= 1'b0;
        cyc(20 * MSC);
        press(600);
        wait_out(1'b1, 1);
        // Check wired off: a welded closed loop must no longer trip
        @(posedge mclk);
        fb_en <= 1'b0;
        set_sense(4, 1'b1);
        cyc(10 * MSC);
        @(posedge mclk);
        stuck <= 1'b1;
        set_sense(4, 1'b0);
        wait_out(1'b1, 50);
        cyc(400 * MSC);
        chk("fb check disabled", 1'b0, status.fb_fault);
        outs(1'b1);
        @(posedge mclk);
        stuck <= 1'b0;
        cyc(30);
        @(posedge mclk);
        fb_en <= 1'b1;
    endtask

    task automatic t_casc();
        logic [1:0] seen;
        seen = 2'h0;
        @(posedge mclk);
        master <= 1'b1;
        sl_present <= 2'h3;
        for (int i = 0; i < 8; i++) begin
            cyc(3);
            chk("slot one-hot", 1'b1, $onehot(slots));
            seen = seen | slots;
        end
        chk("both slaves served", 1'b1, seen == 2'h3);
        outs(1'b1);
        @(posedge mclk);
        sl_clear <= 2'h1;
        wait_out(1'b0, 2);
        @(posedge mclk);
        sl_clear <= 2'h3;
        wait_out(1'b1, 200);
        @(posedge mclk);
        master <= 1'b0;
        cyc(5);
        chk("slots idle as slave", 1'b1, slots == 2'h0);
    endtask

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge mclk);
        err_total++;
        results();
    end

    initial begin
        err_total = 0;
        compares = 0;
        rst = 1'b1;
        btn = 1'b0;
        auto_s = 1'b1;
        fb_en = 1'b1;
        master = 1'b0;
        stuck = 1'b0;
        sl_clear = 2'h3;
        // Slaves connected from the start so their verdicts are fresh at the role change
        sl_present = 2'h3;
        sense = 5'h03;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        wait_out(1'b1, 2);
        chk("field clear", 1'b1, fclr);
        t_hazard();
        t_fault();
        t_fb();
        t_casc();
        results();
    end
endmodule
